//--- logic/timer_pkg.sv
// shared constants, register map and state types of one timer channel
package timer_pkg;

  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_COUNTER = 8'h08;
  localparam logic [7:0] ADDR_RELOAD = 8'h0C;
  localparam logic [7:0] ADDR_COMPARE = 8'h10;
  localparam logic [7:0] ADDR_START = 8'h14;
  localparam logic [7:0] ADDR_STOP = 8'h18;
  localparam logic [7:0] ADDR_EDGE_SEL = 8'h1C;

  // ==========================================================
  // field layout
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned CTRL_MODE_LSB = 3;
  localparam int unsigned CTRL_CLK_LSB = 0;
  localparam int unsigned FLAG_WRAP_BIT = 0;
  localparam int unsigned FLAG_MATCH_BIT = 1;
  localparam int unsigned NUM_CHANNELS = 6;
  localparam int unsigned EXT_CLK_CHANNELS = 2;
  localparam int unsigned PRE_W = 7;

  // ==========================================================
  // reset values
  localparam logic [CTRL_W-1:0] CONTROL_RST = 5'h00;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [15:0] COUNTER_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] COMPARE_RST = 16'h0000;
  localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

  // ==========================================================
  // encodings
  localparam logic [2:0] CLKSEL_SYS = 3'h0;
  localparam logic [2:0] CLKSEL_EXT_RISE = 3'h6;
  localparam logic [2:0] CLKSEL_EXT_FALL = 3'h7;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef enum logic [1:0] {
    MODE_AUTO_RELOAD = 2'b00,
    MODE_COMPARE_OUTPUT = 2'b01,
    MODE_PULSE_WIDTH = 2'b10,
    MODE_INPUT_LATCH = 2'b11
  } mode_t;

  // ==========================================================
  // bus carriers and channel state record
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [CTRL_W-1:0] control;
    logic [1:0] flags;
    logic [15:0] counter;
    logic [15:0] reload;
    logic [15:0] compare;
    logic enable;
    logic [1:0] edge_sel;
    logic [PRE_W-1:0] prescale;
    logic ext_clk_prev;
    logic timer_in_prev;
    logic [31:0] rdata;
    logic wrap_irq;
    logic match_irq;
  } channel_state_t;

  localparam channel_state_t STATE_RST = '{
    control: CONTROL_RST, flags: FLAGS_RST, counter: COUNTER_RST,
    reload: RELOAD_RST, compare: COMPARE_RST, enable: 1'b0,
    edge_sel: EDGE_NONE, prescale: 7'h00, ext_clk_prev: 1'b0,
    timer_in_prev: 1'b0, rdata: RDATA_UNMAPPED, wrap_irq: 1'b0,
    match_irq: 1'b0};

endpackage

//--- logic/timer_channel.sv
// one channel of the multi-mode 16-bit timer with its apb register set
// Contract
// - control is 8 bits, upper three reserved zero
// - clock codes 0..5 pick system, base/2..base/32
// - codes 6/7: ext edges ch0-1, else base/64,/128
// - mode codes: reload, compare, pulse width, capture
// - flags: write one clears, zero keeps
// - reload and pulse modes never touch match flag
// - compare equal sets match flag and irq
// - capture pin event sets match flag and irq
// - overflow sets wrap flag in every mode
// - 16-bit counter increments per count tick
// - start bit starts, stop bit stops counter
// - overflow raises wrap irq, loads reload value
// - counter write also copies into reload
// - all registers read zero after reset
// - compare register is the compare value
// - capture copies counter into compare register
// - start/stop registers set/clear enable, zeros ignored
// - edge select: none, rising, falling, both
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps

module timer_channel #(
  parameter int unsigned CHANNEL_IDX = 0
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire timer_pkg::apb_req_t i_apb,
  output timer_pkg::apb_rsp_t o_apb,
  input wire logic i_base_tick,
  input wire logic i_ext_clk,
  input wire logic i_timer_in,
  output logic o_counter_wrap_irq,
  output logic o_match_or_capture_irq
);

  // ==========================================================
  // helpers
  function automatic logic div_tick(input logic [timer_pkg::PRE_W-1:0] pre,
                                    input logic base, input int unsigned k);
    logic hit;
    hit = base;
    for (int unsigned b = 0; b < timer_pkg::PRE_W; b++) begin
      if (b < k) begin
        hit = hit & pre[b];
      end
    end
    return hit;
  endfunction

  function automatic logic addr_is(input logic [timer_pkg::ADDR_W-1:0] a,
                                   input logic [timer_pkg::ADDR_W-1:0] off);
    return a == off;
  endfunction

  timer_pkg::channel_state_t st_r;
  timer_pkg::channel_state_t st_nxt;

  // ==========================================================
  // bus decode
  logic setup_ph;
  logic wr_acc;
  logic mapped;
  timer_pkg::mode_t mode;
  logic [2:0] clk_code;
  logic count_tick;
  logic ext_rise;
  logic ext_fall;
  logic pin_rise;
  logic pin_fall;
  logic capture_ev;
  logic running;
  logic wrap_ev;
  logic match_ev;
  logic [15:0] count_inc;
  logic [31:0] rd_mux;

  assign setup_ph = i_apb.psel & ~i_apb.penable;
  assign wr_acc = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign mapped = addr_is(i_apb.paddr, timer_pkg::ADDR_CONTROL)
                | addr_is(i_apb.paddr, timer_pkg::ADDR_FLAGS)
                | addr_is(i_apb.paddr, timer_pkg::ADDR_COUNTER)
                | addr_is(i_apb.paddr, timer_pkg::ADDR_RELOAD)
                | addr_is(i_apb.paddr, timer_pkg::ADDR_COMPARE)
                | addr_is(i_apb.paddr, timer_pkg::ADDR_START)
                | addr_is(i_apb.paddr, timer_pkg::ADDR_STOP)
                | addr_is(i_apb.paddr, timer_pkg::ADDR_EDGE_SEL);

  // zero wait states: read data is caught in the setup cycle
  assign o_apb.pready = 1'b1;
  assign o_apb.pslverr = i_apb.psel & i_apb.penable & ~mapped;
  assign o_apb.prdata = st_r.rdata;
  assign o_counter_wrap_irq = st_r.wrap_irq;
  assign o_match_or_capture_irq = st_r.match_irq;

  // ==========================================================
  // count source selection
  assign mode = timer_pkg::mode_t'(st_r.control[timer_pkg::CTRL_MODE_LSB +: 2]);
  assign clk_code = st_r.control[timer_pkg::CTRL_CLK_LSB +: 3];
  // pins are taken as synchronous, so one register suffices for edges
  assign ext_rise = i_ext_clk & ~st_r.ext_clk_prev;
  assign ext_fall = ~i_ext_clk & st_r.ext_clk_prev;
  assign pin_rise = i_timer_in & ~st_r.timer_in_prev;
  assign pin_fall = ~i_timer_in & st_r.timer_in_prev;

  always_comb begin
    if (clk_code == timer_pkg::CLKSEL_SYS) begin
      count_tick = 1'b1;
    end else if (clk_code >= timer_pkg::CLKSEL_EXT_RISE
                 && CHANNEL_IDX < timer_pkg::EXT_CLK_CHANNELS) begin
      count_tick = (clk_code == timer_pkg::CLKSEL_EXT_RISE) ? ext_rise : ext_fall;
    end else begin
      // code k selects the base tick divided by 2^k
      count_tick = div_tick(st_r.prescale, i_base_tick, {29'h0, clk_code});
    end
  end

  assign running = st_r.enable & count_tick;
  assign wrap_ev = running & (st_r.counter == timer_pkg::COUNTER_MAX);
  assign count_inc = st_r.counter + 16'h0001;
  // compare looks at the value the counter takes on this tick
  assign match_ev = running & ~wrap_ev & (mode == timer_pkg::MODE_COMPARE_OUTPUT)
                  & (count_inc == st_r.compare);

  always_comb begin
    case (st_r.edge_sel)
      timer_pkg::EDGE_RISE: capture_ev = pin_rise;
      timer_pkg::EDGE_FALL: capture_ev = pin_fall;
      timer_pkg::EDGE_BOTH: capture_ev = pin_rise | pin_fall;
      default: capture_ev = 1'b0;
    endcase
    if (mode != timer_pkg::MODE_INPUT_LATCH) begin
      capture_ev = 1'b0;
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    rd_mux = timer_pkg::RDATA_UNMAPPED;
    case (i_apb.paddr)
      timer_pkg::ADDR_CONTROL: rd_mux = {27'h0, st_r.control};
      timer_pkg::ADDR_FLAGS: rd_mux = {30'h0, st_r.flags};
      timer_pkg::ADDR_COUNTER: rd_mux = {16'h0, st_r.counter};
      timer_pkg::ADDR_RELOAD: rd_mux = {16'h0, st_r.reload};
      timer_pkg::ADDR_COMPARE: rd_mux = {16'h0, st_r.compare};
      timer_pkg::ADDR_START: rd_mux = {31'h0, st_r.enable} << CHANNEL_IDX;
      timer_pkg::ADDR_EDGE_SEL: rd_mux = {30'h0, st_r.edge_sel};
      default: rd_mux = timer_pkg::RDATA_UNMAPPED;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.ext_clk_prev = i_ext_clk;
    st_nxt.timer_in_prev = i_timer_in;
    st_nxt.wrap_irq = wrap_ev;
    st_nxt.match_irq = match_ev | capture_ev;
    if (i_base_tick) begin
      st_nxt.prescale = st_r.prescale + 7'h01;
    end
    if (setup_ph) begin
      st_nxt.rdata = rd_mux;
    end

    // counting; a software counter write below overrides the tick
    if (wrap_ev) begin
      st_nxt.counter = st_r.reload;
    end else if (running) begin
      st_nxt.counter = count_inc;
    end

    // software writes, taken in the access phase
    if (wr_acc) begin
      case (i_apb.paddr)
        timer_pkg::ADDR_CONTROL: begin
          st_nxt.control = i_apb.pwdata[timer_pkg::CTRL_W-1:0];
        end
        timer_pkg::ADDR_FLAGS: begin
          st_nxt.flags = st_r.flags & ~i_apb.pwdata[1:0];
        end
        timer_pkg::ADDR_COUNTER: begin
          st_nxt.counter = i_apb.pwdata[15:0];
          st_nxt.reload = i_apb.pwdata[15:0];
        end
        timer_pkg::ADDR_RELOAD: begin
          st_nxt.reload = i_apb.pwdata[15:0];
        end
        timer_pkg::ADDR_COMPARE: begin
          st_nxt.compare = i_apb.pwdata[15:0];
        end
        timer_pkg::ADDR_START: begin
          if (i_apb.pwdata[CHANNEL_IDX]) begin
            st_nxt.enable = 1'b1;
          end
        end
        timer_pkg::ADDR_STOP: begin
          if (i_apb.pwdata[CHANNEL_IDX]) begin
            st_nxt.enable = 1'b0;
          end
        end
        timer_pkg::ADDR_EDGE_SEL: begin
          st_nxt.edge_sel = i_apb.pwdata[1:0];
        end
        default: begin
        end
      endcase
    end

    // hardware events win over a clear in the same cycle
    if (capture_ev) begin
      st_nxt.compare = st_r.counter;
    end
    if (wrap_ev) begin
      st_nxt.flags[timer_pkg::FLAG_WRAP_BIT] = 1'b1;
    end
    if (match_ev | capture_ev) begin
      st_nxt.flags[timer_pkg::FLAG_MATCH_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= timer_pkg::STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // checks
  logic cnt_wr;
  logic flag_wr;
  assign cnt_wr = wr_acc & (i_apb.paddr == timer_pkg::ADDR_COUNTER);
  assign flag_wr = wr_acc & (i_apb.paddr == timer_pkg::ADDR_FLAGS);

  a_wrap_reload: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wrap_ev && !cnt_wr |=> st_r.counter == $past(st_r.reload) && o_counter_wrap_irq)
    else $error("wrap did not reload counter and raise irq");

  a_wrap_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wrap_ev |=> st_r.flags[timer_pkg::FLAG_WRAP_BIT] && o_counter_wrap_irq)
    else $error("wrap flag or wrap irq not raised");

  // a reload of all ones wraps on every tick, so the irq may stay high; only its source is checked
  a_wrap_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !wrap_ev |=> !o_counter_wrap_irq)
    else $error("wrap irq without overflow");

  a_match_event: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    running && mode == timer_pkg::MODE_COMPARE_OUTPUT && count_inc == st_r.compare
    && !wrap_ev |=> st_r.flags[timer_pkg::FLAG_MATCH_BIT] && o_match_or_capture_irq)
    else $error("compare match not flagged");

  a_match_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (mode == timer_pkg::MODE_AUTO_RELOAD || mode == timer_pkg::MODE_PULSE_WIDTH)
    && !st_r.flags[timer_pkg::FLAG_MATCH_BIT] |=> !st_r.flags[timer_pkg::FLAG_MATCH_BIT])
    else $error("match flag changed in reload or pulse mode");

  a_flag_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    flag_wr && i_apb.pwdata[0] && !wrap_ev |=> !st_r.flags[timer_pkg::FLAG_WRAP_BIT])
    else $error("write one did not clear wrap flag");

  a_flag_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    flag_wr && !i_apb.pwdata[0] |=> $stable(st_r.flags[timer_pkg::FLAG_WRAP_BIT])
    || $rose(st_r.flags[timer_pkg::FLAG_WRAP_BIT]))
    else $error("write zero changed wrap flag");

  a_counter_copy: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cnt_wr |=> st_r.counter == $past(i_apb.pwdata[15:0])
    && st_r.reload == $past(i_apb.pwdata[15:0]))
    else $error("counter write not copied to reload");

  a_capture_copy: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    capture_ev |=> st_r.compare == $past(st_r.counter) && o_match_or_capture_irq)
    else $error("capture did not latch counter");

  a_start_stop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_acc && i_apb.paddr == timer_pkg::ADDR_STOP && i_apb.pwdata[CHANNEL_IDX]
    |=> !st_r.enable ##1 $stable(st_r.counter) || st_r.enable)
    else $error("stopped counter still moved");

  a_sys_count: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st_r.enable && clk_code == timer_pkg::CLKSEL_SYS && !wr_acc && !wrap_ev
    |=> st_r.counter == $past(st_r.counter) + 16'h0001)
    else $error("system clock source did not count every cycle");

  a_reset_zero: assert property (@(posedge i_clk)
    $past(i_sys_rst) |-> st_r.control == timer_pkg::CONTROL_RST
    && st_r.flags == timer_pkg::FLAGS_RST && st_r.counter == timer_pkg::COUNTER_RST
    && st_r.compare == timer_pkg::COMPARE_RST)
    else $error("registers not zero after reset");

  a_match_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !match_ev && !capture_ev |=> !o_match_or_capture_irq)
    else $error("match irq without event");

  a_stop_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !st_r.enable && !cnt_wr |=> $stable(st_r.counter))
    else $error("stopped counter moved");

  a_start_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_acc && i_apb.paddr == timer_pkg::ADDR_START && i_apb.pwdata[CHANNEL_IDX] |=> st_r.enable)
    else $error("start bit did not enable channel");

  a_start_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_acc && (i_apb.paddr == timer_pkg::ADDR_START || i_apb.paddr == timer_pkg::ADDR_STOP)
    && !i_apb.pwdata[CHANNEL_IDX] |=> $stable(st_r.enable))
    else $error("zero in start or stop register changed enable");

  a_control_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_acc && i_apb.paddr == timer_pkg::ADDR_CONTROL
    |=> st_r.control == $past(i_apb.pwdata[timer_pkg::CTRL_W-1:0]))
    else $error("control write not taken");

  a_control_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    setup_ph && i_apb.paddr == timer_pkg::ADDR_CONTROL |=> o_apb.prdata[31:timer_pkg::CTRL_W] == '0)
    else $error("reserved control bits read nonzero");

  a_reserved_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    setup_ph && i_apb.paddr == timer_pkg::ADDR_FLAGS |=> o_apb.prdata[31:2] == '0)
    else $error("reserved flag bits read nonzero");

  a_compare_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_acc && i_apb.paddr == timer_pkg::ADDR_COMPARE && !capture_ev
    |=> st_r.compare == $past(i_apb.pwdata[15:0]))
    else $error("compare write not taken");

  a_reload_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_acc && i_apb.paddr == timer_pkg::ADDR_RELOAD |=> st_r.reload == $past(i_apb.pwdata[15:0]))
    else $error("reload write not taken");

  a_ext_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st_r.enable && clk_code == timer_pkg::CLKSEL_EXT_RISE && !ext_rise && !cnt_wr
    && CHANNEL_IDX < timer_pkg::EXT_CLK_CHANNELS |=> $stable(st_r.counter))
    else $error("external rise source counted without a rise");

  a_ext_fall: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st_r.enable && clk_code == timer_pkg::CLKSEL_EXT_FALL && ext_fall && !cnt_wr && !wrap_ev
    && CHANNEL_IDX < timer_pkg::EXT_CLK_CHANNELS
    |=> st_r.counter == $past(st_r.counter) + 16'h0001)
    else $error("external fall did not count");

  // the ignore setting must hold off captures even while the pin toggles
  a_capture_none: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    mode == timer_pkg::MODE_INPUT_LATCH && st_r.edge_sel == timer_pkg::EDGE_NONE
    && !st_r.flags[timer_pkg::FLAG_MATCH_BIT] |=> !st_r.flags[timer_pkg::FLAG_MATCH_BIT])
    else $error("ignored edge setting still captured");

endmodule // timer_channel

//--- sim/timer_pins_model.sv
// pin-side model of one timer channel: base tick source, count clock pin, capture pin
`timescale 1ns/1ps

module timer_pins_model #(
  parameter int unsigned BASE_PERIOD = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ext_lvl,
  input wire logic i_cap_lvl,
  output logic o_base_tick,
  output logic o_ext_clk,
  output logic o_timer_in
);
  int unsigned div_cnt;

  // pins move only after an edge, as a synchronised pad would deliver them
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_cnt <= 0;
      o_base_tick <= 1'b0;
      o_ext_clk <= 1'b0;
      o_timer_in <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == BASE_PERIOD - 1) ? 0 : div_cnt + 1;
      o_base_tick <= (div_cnt == BASE_PERIOD - 1);
      o_ext_clk <= i_ext_lvl;
      o_timer_in <= i_cap_lvl;
    end
  end
endmodule // timer_pins_model

//--- sim/test_multi_mode_timer_channel_regs.sv
// self-checking bench for timer channels 0 and 2 driven over one apb bus
`timescale 1ns/1ps

module test_multi_mode_timer_channel_regs;
  logic i_clk;
  logic i_sys_rst;
  timer_pkg::apb_req_t req;
  timer_pkg::apb_rsp_t rsp;
  logic base_tick;
  logic ext_clk;
  logic timer_in;
  logic ext_lvl;
  logic cap_lvl;
  logic wrap_irq;
  logic match_irq;
  logic [31:0] rd;
  timer_pkg::apb_rsp_t rsp_hi;
  logic [31:0] rd_hi;
  logic err;
  int n_fail;
  int check_count;
  int got;

  timer_channel #(.CHANNEL_IDX(0)) i_timer_channel (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_apb(req), .o_apb(rsp), .i_base_tick(base_tick), .i_ext_clk(ext_clk),
    .i_timer_in(timer_in), .o_counter_wrap_irq(wrap_irq), .o_match_or_capture_irq(match_irq));

  // a channel without external clock pins shares the bus; only its start and stop bits differ
  timer_channel #(.CHANNEL_IDX(2)) i_timer_channel_2 (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_apb(req), .o_apb(rsp_hi), .i_base_tick(base_tick), .i_ext_clk(ext_clk),
    .i_timer_in(timer_in), .o_counter_wrap_irq(), .o_match_or_capture_irq());

  timer_pins_model #(.BASE_PERIOD(4)) i_timer_pins_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_ext_lvl(ext_lvl), .i_cap_lvl(cap_lvl), .o_base_tick(base_tick), .o_ext_clk(ext_clk),
    .o_timer_in(timer_in));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ==========================================================
  // bus and checking tasks
  task automatic print_verdict();
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // request held from setup until pready is seen high at an edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      print_verdict();
    end
    rd = rsp.prdata;
    rd_hi = rsp_hi.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(a, 1'b0, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  // irq outputs are one-cycle pulses, so every cycle is looked at
  task automatic wait_irq(input logic sel);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while ((sel ? match_irq : wrap_irq) !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      n_fail++;
      print_verdict();
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    req = '0;
    ext_lvl = 1'b0;
    cap_lvl = 1'b0;
    n_fail = 0;
    check_count = 0;
    i_sys_rst = 1'b1;
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rdchk(8'(a * 4), 32'h0000_0000, "reset value");
    end
    rdchk(8'h40, 32'h0000_0000, "unmapped read");
    check("unmapped error", 32'(err), 32'h0000_0001);
    // reserved control bits are written as zero and must read back zero
    wr(timer_pkg::ADDR_CONTROL, 32'h0000_001F);
    rdchk(timer_pkg::ADDR_CONTROL, 32'h0000_001F, "control fields");
    // reload then pulse width: counting passes the compare value without a match
    for (int m = 0; m < 2; m++) begin
      wr(timer_pkg::ADDR_CONTROL, m ? 32'h0000_0010 : 32'h0000_0000);
      wr(timer_pkg::ADDR_COMPARE, 32'h0000_FFF8);
      wr(timer_pkg::ADDR_COUNTER, 32'h0000_FFF0);
      rdchk(timer_pkg::ADDR_RELOAD, 32'h0000_FFF0, "reload copy");
      wr(timer_pkg::ADDR_START, 32'h0000_0001);
      wait_irq(1'b0);
      wr(timer_pkg::ADDR_STOP, 32'h0000_0001);
      rdchk(timer_pkg::ADDR_FLAGS, 32'h0000_0001, "wrap flag only");
      xfer(timer_pkg::ADDR_COUNTER, 1'b0, 32'h0000_0000);
      check("reloaded", 32'(rd >= 32'h0000_FFF0 && rd < 32'h0000_FFF8), 32'h1);
      rdchk(timer_pkg::ADDR_COUNTER, rd, "stopped counter");
      wr(timer_pkg::ADDR_FLAGS, 32'h0000_0000);
      rdchk(timer_pkg::ADDR_FLAGS, 32'h0000_0001, "zero keeps flag");
      wr(timer_pkg::ADDR_FLAGS, 32'h0000_0001);
      rdchk(timer_pkg::ADDR_FLAGS, 32'h0000_0000, "one clears flag");
    end
    wr(timer_pkg::ADDR_CONTROL, 32'h0000_0008);
    wr(timer_pkg::ADDR_COMPARE, 32'h0000_0010);
    wr(timer_pkg::ADDR_COUNTER, 32'h0000_0000);
    wr(timer_pkg::ADDR_START, 32'h0000_0001);
    wait_irq(1'b1);
    wr(timer_pkg::ADDR_STOP, 32'h0000_0001);
    rdchk(timer_pkg::ADDR_FLAGS, 32'h0000_0002, "match flag");
    wr(timer_pkg::ADDR_FLAGS, 32'h0000_0002);
    // capture on a stopped channel, one rise and one fall per edge code
    wr(timer_pkg::ADDR_CONTROL, 32'h0000_0018);
    for (int e = 0; e < 4; e++) begin
      wr(timer_pkg::ADDR_EDGE_SEL, 32'(e));
      wr(timer_pkg::ADDR_COUNTER, 32'(32'h100 + e));
      wr(timer_pkg::ADDR_COMPARE, 32'h0000_0000);
      cap_lvl <= 1'b1;
      repeat (4) @(posedge i_clk);
      rdchk(timer_pkg::ADDR_FLAGS, e[0] ? 32'h2 : 32'h0, "rise event");
      wr(timer_pkg::ADDR_FLAGS, 32'h0000_0002);
      cap_lvl <= 1'b0;
      repeat (4) @(posedge i_clk);
      rdchk(timer_pkg::ADDR_FLAGS, e[1] ? 32'h2 : 32'h0, "fall event");
      rdchk(timer_pkg::ADDR_COMPARE, e ? 32'(32'h100 + e) : 32'h0, "captured");
      wr(timer_pkg::ADDR_FLAGS, 32'h0000_0002);
    end
    // divided base clocks: 64 base ticks in the window, one count of slack
    for (int k = 1; k < 6; k++) begin
      wr(timer_pkg::ADDR_CONTROL, 32'(k));
      wr(timer_pkg::ADDR_COUNTER, 32'h0000_0000);
      wr(timer_pkg::ADDR_START, 32'h0000_0001);
      repeat (256) @(posedge i_clk);
      wr(timer_pkg::ADDR_STOP, 32'h0000_0001);
      xfer(timer_pkg::ADDR_COUNTER, 1'b0, 32'h0000_0000);
      got = int'(rd[15:0]) - (64 >> k);
      check("divided count", 32'(got >= -1 && got <= 1), 32'h1);
    end
    // pin ends high, so code 6 sees six rises and code 7 five falls
    for (int k = 6; k < 8; k++) begin
      wr(timer_pkg::ADDR_CONTROL, 32'(k));
      wr(timer_pkg::ADDR_COUNTER, 32'h0000_0000);
      wr(timer_pkg::ADDR_START, 32'h0000_0001);
      ext_lvl <= 1'b1;
      repeat (3) @(posedge i_clk);
      repeat (5) begin
        ext_lvl <= 1'b0;
        repeat (3) @(posedge i_clk);
        ext_lvl <= 1'b1;
        repeat (3) @(posedge i_clk);
      end
      wr(timer_pkg::ADDR_STOP, 32'h0000_0001);
      rdchk(timer_pkg::ADDR_COUNTER, (k == 6) ? 32'h6 : 32'h5, "pin edges");
    end
    // channel two: codes 6/7 divide the base tick by 64 and 128; channel 0 stays stopped
    for (int k = 6; k < 8; k++) begin
      wr(timer_pkg::ADDR_CONTROL, 32'(k));
      wr(timer_pkg::ADDR_COUNTER, 32'h0000_0000);
      wr(timer_pkg::ADDR_START, 32'h0000_0004);
      xfer(timer_pkg::ADDR_START, 1'b0, 32'h0000_0000);
      check("start bit two", rd_hi, 32'h0000_0004);
      check("start bit zero", rd, 32'h0000_0000);
      repeat (2048) @(posedge i_clk);
      wr(timer_pkg::ADDR_STOP, 32'h0000_0004);
      xfer(timer_pkg::ADDR_COUNTER, 1'b0, 32'h0000_0000);
      check("idle channel", rd, 32'h0000_0000);
      got = int'(rd_hi[15:0]) - (512 >> k);
      check("slow divided count", 32'(got >= -1 && got <= 1), 32'h1);
    end
    print_verdict();
  end
endmodule // test_multi_mode_timer_channel_regs
